// ### testbench/analog_front.sv
// Model: analog inputs and comparator beyond the converter control
// Assumes: bench sets the levels; answer follows the trial word at once
`timescale 1ns/10ps
`default_nettype none
module analog_front (
  input  wire logic        i_clk_sys,
  input  wire logic [4:0]  i_chan_sel,
  input  wire logic        i_chan_en,
  input  wire logic [11:0] i_dac,
  output logic             o_cmp_hi
);
  logic [11:0] level [32];
  logic        junk_r = 1'b0;
  initial begin
    foreach (level[k]) level[k] = 12'h000;
  end
  // Unselected output toggles, never a stale answer
  always_ff @(posedge i_clk_sys) junk_r <= ~junk_r;
  assign o_cmp_hi = i_chan_en ? level[i_chan_sel] >= i_dac : junk_r;
endmodule : analog_front
`default_nettype wire

// ### testbench/conv_ctrl_assertions.sv
// Checker: port relations of the converter control top
// Assumes: bound into conv_ctrl; one clock, async active-low reset
`timescale 1ns/10ps
`default_nettype none
module conv_ctrl_assertions #(
  parameter int CHANNELS = 28
) (
  input wire logic       i_clk_sys,
  input wire logic       i_rst_n,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic       i_hw_trig,
  input wire logic [4:0] o_chan_sel,
  input wire logic       o_chan_en,
  input wire logic       o_sampling,
  input wire logic       o_conv_irq
);
  // ---------------------------------------
  // Shadow of trigger select and stop2
  // ---------------------------------------
  logic trg_r;
  logic stop2_r;
  wire  sc1_wr = i_wr && i_addr == 4'h0;
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      trg_r   <= 1'b0;
      stop2_r <= 1'b0;
    end else if (i_wr && i_addr == 4'h1) begin
      trg_r   <= i_wdata[6];
    end else if (i_wr && i_addr == 4'h7) begin
      stop2_r <= i_wdata[1];
    end
  end
  // ---------------------------------------
  // Properties
  // ---------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  sequence hw_rise;
    trg_r && !stop2_r && !o_chan_en && o_chan_sel != 5'h1f ##1 $rose(i_hw_trig);
  endsequence
  chan_follow_a: assert property (sc1_wr |=> o_chan_sel == $past(i_wdata[4:0]))
    else $error("channel select differs from write");
  off_idle_a: assert property (o_chan_sel == 5'h1f |-> !o_chan_en)
    else $error("converting with channel off");
  sw_start_a: assert property (sc1_wr && !trg_r && i_wdata[4:0] != 5'h1f |-> ##[1:3] o_chan_en)
    else $error("software write did not start");
  hw_hold_a: assert property (sc1_wr && trg_r && !o_chan_en
    && !i_hw_trig && !$past(i_hw_trig) |=> !o_chan_en)
    else $error("write started conversion in hardware mode");
  hw_start_a: assert property (hw_rise |-> ##[1:6] o_chan_en)
    else $error("trigger edge did not start");
  wr_clear_a: assert property (sc1_wr && !$past(o_chan_en) |=> !o_conv_irq)
    else $error("flag survived control write");
  rd_clear_a: assert property (i_rd && i_addr == 4'h3 && !$past(o_chan_en) |=> !o_conv_irq)
    else $error("flag survived low result read");
  samp_busy_a: assert property (o_sampling |-> o_chan_en)
    else $error("sampling while idle");
  irq_done_a: assert property ($rose(o_conv_irq) && !$past(i_wr)
    |-> $past(o_chan_en) || $past(o_chan_en, 2))
    else $error("flag without a conversion");
endmodule : conv_ctrl_assertions
bind conv_ctrl conv_ctrl_assertions #(.CHANNELS(CHANNELS)) u_conv_chk (
  .i_clk_sys (i_clk_sys),
  .i_rst_n   (i_rst_n),
  .i_addr    (i_addr),
  .i_wdata   (i_wdata),
  .i_wr      (i_wr),
  .i_rd      (i_rd),
  .i_hw_trig (i_hw_trig),
  .o_chan_sel(o_chan_sel),
  .o_chan_en (o_chan_en),
  .o_sampling(o_sampling),
  .o_conv_irq(o_conv_irq)
);
`default_nettype wire

// ### testbench/tb.sv
// Testbench: converter control checked against a result model
// Assumes: analog_front answers the comparator; bus clock 50 MHz
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        i_clk_sys   = 1'b0;
  logic        i_rst_n     = 1'b0;
  logic [3:0]  i_addr      = 4'h0;
  logic [7:0]  i_wdata     = 8'h00;
  logic        i_wr        = 1'b0;
  logic        i_rd        = 1'b0;
  logic        i_hw_trig   = 1'b0;
  logic        i_alt_clk   = 1'b0;
  logic        i_local_clk = 1'b0;
  logic        cmp_hi;
  logic [7:0]  o_rdata;
  logic [4:0]  o_chan_sel;
  logic        o_chan_en;
  logic [11:0] o_dac;
  logic        o_sampling;
  logic        o_conv_irq;
  int          error_cnt   = 0;
  int          num_checks  = 0;
  logic [7:0]  rv;
  logic [7:0]  cfg;
  logic [7:0]  pwr [4]     = '{8'h00, 8'h01, 8'h04, 8'h02};
  logic [4:0]  rsv [3]     = '{5'h18, 5'h19, 5'h1c};

  initial forever #10 i_clk_sys = ~i_clk_sys;
  initial begin
    #3;
    forever #50 i_alt_clk = ~i_alt_clk;
  end
  initial begin
    #7;
    forever #500 i_local_clk = ~i_local_clk;
  end

  conv_ctrl #(.CHANNELS(28)) u_dut (
    .i_clk_sys  (i_clk_sys),
    .i_rst_n    (i_rst_n),
    .i_addr     (i_addr),
    .i_wdata    (i_wdata),
    .i_wr       (i_wr),
    .i_rd       (i_rd),
    .o_rdata    (o_rdata),
    .i_hw_trig  (i_hw_trig),
    .i_alt_clk  (i_alt_clk),
    .i_local_clk(i_local_clk),
    .i_cmp_hi   (cmp_hi),
    .o_chan_sel (o_chan_sel),
    .o_chan_en  (o_chan_en),
    .o_dac      (o_dac),
    .o_sampling (o_sampling),
    .o_conv_irq (o_conv_irq)
  );
  analog_front u_ana (
    .i_clk_sys (i_clk_sys),
    .i_chan_sel(o_chan_sel),
    .i_chan_en (o_chan_en),
    .i_dac     (o_dac),
    .o_cmp_hi  (cmp_hi)
  );

  // ---------------------------------------
  // Bus cycles, model and comparison
  // ---------------------------------------
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clk_sys);
    i_wr    <= 1'b0;
    @(posedge i_clk_sys);
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk_sys);
    i_rd   <= 1'b0;
    @(posedge i_clk_sys);
    d = o_rdata;
  endtask : rd
  function automatic logic [11:0] fmt(input logic [11:0] v, input logic [1:0] mode);
    int sh;
    sh = (mode == conv_ctrl_pkg::MODE_8) ? 4 : (mode == conv_ctrl_pkg::MODE_10) ? 2 : 0;
    return 12'(int'(v) >> sh);
  endfunction : fmt
  task automatic wait_irq;
    int n;
    n = 0;
    while (o_conv_irq !== 1'b1 && n < 12000) begin
      @(posedge i_clk_sys);
      n++;
    end
    chk(o_conv_irq, 1'b1);
  endtask : wait_irq
  task automatic read_res(input logic [11:0] ex, input logic val);
    logic [7:0] hi;
    rd(4'h2, hi);
    rd(4'h3, rv);
    if (val) chk({hi[3:0], rv}, ex);
    chk(o_conv_irq, 1'b0);
  endtask : read_res
  task automatic conv(input logic [4:0] c, input logic [11:0] v, input logic [7:0] cf,
                      input logic [7:0] sc2, input logic ex);
    int n;
    u_ana.level[c] = v;
    wr(4'h6, cf);
    wr(4'h1, sc2);
    wr(4'h0, {3'b010, c});
    n = 0;
    while (o_chan_en !== 1'b0 && n < 12000) begin
      @(posedge i_clk_sys);
      n++;
    end
    repeat (2) @(posedge i_clk_sys);
    chk(o_conv_irq, ex);
    rd(4'h1, rv);
    chk(rv[7], 1'b0);
    if (ex) read_res(fmt(v, cf[3:2]), c != rsv[0] && c != rsv[1] && c != rsv[2]);
  endtask : conv
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude

  // ---------------------------------------
  // Scenarios
  // ---------------------------------------
  initial begin
    void'($urandom(32'h973c11f6));
    repeat (4) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    @(posedge i_clk_sys);
    rd(4'h0, rv);
    chk(rv, conv_ctrl_pkg::SC1_RST);
    rd(4'hc, rv);
    chk(rv, 8'h00);
    chk(o_chan_en, 1'b0);
    $display("reset test done");
    for (int m = 0; m < 3; m++) begin
      for (int s = 0; s < 4; s++) begin
        cfg = {1'b0, 2'($urandom), 1'b0, 2'(m), 2'(s)};
        conv(5'($urandom_range(23)), 12'($urandom), cfg, 8'h00, 1'b1);
      end
    end
    conv(conv_ctrl_pkg::CH_BANDGAP, 12'($urandom), 8'h17, 8'h00, 1'b1);
    conv(conv_ctrl_pkg::CH_TEMP, 12'($urandom), 8'h17, 8'h00, 1'b1);
    foreach (rsv[i]) conv(rsv[i], 12'($urandom), 8'h04, 8'h00, 1'b1);
    $display("format and channel test done");
    wr(4'h4, 8'h08);
    wr(4'h5, 8'h00);
    for (int i = 0; i < 4; i++) begin
      conv(5'h03, 12'h7ff + 12'(i % 2), 8'h04, {3'b001, i[1], 4'h0},
           (i > 1) == (i % 2 == 1));
    end
    $display("compare test done");
    wr(4'h0, 8'h45);
    repeat (5) @(posedge i_clk_sys);
    conv(5'h09, 12'($urandom), 8'h04, 8'h00, 1'b1);
    wr(4'h0, 8'h45);
    repeat (5) @(posedge i_clk_sys);
    wr(4'h0, 8'h5f);
    repeat (40) @(posedge i_clk_sys);
    chk({o_chan_en, o_conv_irq}, 2'b00);
    $display("abort test done");
    u_ana.level[11] = 12'($urandom);
    wr(4'h1, 8'h40);
    wr(4'h0, 8'h4b);
    repeat (40) @(posedge i_clk_sys);
    chk(o_chan_en, 1'b0);
    foreach (pwr[i]) begin
      wr(4'h7, pwr[i]);
      i_hw_trig <= 1'b1;
      if (i < 3) begin
        wait_irq;
        read_res(u_ana.level[11], 1'b1);
      end
      repeat (60) @(posedge i_clk_sys);
      chk(o_conv_irq, 1'b0);
      i_hw_trig <= 1'b0;
      repeat (4) @(posedge i_clk_sys);
    end
    wr(4'h1, 8'h00);
    $display("hardware trigger test done");
    wr(4'h7, 8'h04);
    wr(4'h6, 8'h06);
    wr(4'h0, 8'h47);
    repeat (300) @(posedge i_clk_sys);
    chk(o_conv_irq, 1'b0);
    wr(4'h0, 8'h5f);
    wr(4'h7, 8'h01);
    conv(5'h11, 12'($urandom), 8'h06, 8'h00, 1'b1);
    wr(4'h7, 8'h00);
    u_ana.level[12] = 12'($urandom);
    wr(4'h0, 8'h6c);
    repeat (2) begin
      wait_irq;
      read_res(u_ana.level[12], 1'b1);
    end
    wr(4'h0, 8'h5f);
    repeat (200) @(posedge i_clk_sys);
    chk({o_chan_en, o_conv_irq}, 2'b00);
    $display("clock source and continuous test done");
    conclude;
  end

  // Whole run is at most about 28000 cycles
  initial begin
    #(90000 * 20);
    error_cnt++;
    conclude;
  end
endmodule : tb
`default_nettype wire

// ### verilog/conv_clk_gen.sv
// Conversion clock enable generator: source select and divide
// Assumes: alternate and local clocks are pins, sampled into the bus clock
`timescale 1ns/10ps
`default_nettype none
module conv_clk_gen (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_n,
  input  wire logic [1:0] i_src,
  input  wire logic [1:0] i_div,
  input  wire logic       i_alt_clk,
  input  wire logic       i_local_clk,
  input  wire logic       i_alt_ok,
  output logic            o_tick
);
  // ----------------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------------
  logic [2:0] alt_sync_r;
  logic [2:0] loc_sync_r;
  logic       half_r;
  logic [2:0] div_cnt_r;
  logic       src_edge;
  logic [2:0] div_lim;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      alt_sync_r <= 3'h0;
      loc_sync_r <= 3'h0;
      half_r     <= 1'b0;
    end else begin
      alt_sync_r <= {alt_sync_r[1:0], i_alt_clk};
      loc_sync_r <= {loc_sync_r[1:0], i_local_clk};
      half_r     <= ~half_r;
    end
  end

  wire alt_rise = alt_sync_r[1] & ~alt_sync_r[2];
  wire loc_rise = loc_sync_r[1] & ~loc_sync_r[2];

  // Alternate source blocked in deep stop
  assign src_edge = (i_src == conv_ctrl_pkg::SRC_BUS)      ? 1'b1 :
                    (i_src == conv_ctrl_pkg::SRC_BUS_DIV2) ? half_r :
                    (i_src == conv_ctrl_pkg::SRC_ALT)      ? (alt_rise & i_alt_ok) :
                                                             loc_rise;

  // ----------------------------------------------------------------------
  // Divider by 1, 2, 4 or 8
  // ----------------------------------------------------------------------
  assign div_lim = 3'((4'h1 << i_div) - 4'h1);

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_cnt_r <= 3'h0;
    end else if (src_edge) begin
      div_cnt_r <= (div_cnt_r >= div_lim) ? 3'h0 : div_cnt_r + 3'h1;
    end
  end

  assign o_tick = src_edge & (div_cnt_r >= div_lim);
endmodule : conv_clk_gen
`default_nettype wire

// ### verilog/conv_ctrl.sv
// Converter control top: register port, triggers, channel, format, compare
// Assumes: one bus clock; analog mux and comparator sit outside
//
// Overview of operation
// - Channel select field picks one of 28 inputs
// - Codes for absent channels are reserved
// - Reserved code still converts; result undefined
// - Code 26 routes the temperature sensor
// - Code 27 routes the internal bandgap
// - Four selectable conversion clock sources
// - Selected source divided by programmable divide field
// - Alternate clock keeps running in wait
// - Alternate clock unusable in stop2 or stop3
// - Counter overflow starts one conversion when enabled
// - Hardware trigger works in run, wait, stop3
// - Control register one write aborts; restarts only with software trigger select
// - Right-justified unsigned 12, 10 or 8 bit result
// - Single or continuous; single returns to idle
// - Optional compare, less-than or greater-equal
// - Complete flag with maskable interrupt
// - Conversions continue in wait and stop3
// - All-ones channel code switches converter off
// - Flag cleared by control write or low read
// - Trigger select picks software or hardware starts
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module conv_ctrl #(
  parameter int CHANNELS = 28
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  input  wire logic [3:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_rdata,
  input  wire logic        i_hw_trig,
  input  wire logic        i_alt_clk,
  input  wire logic        i_local_clk,
  input  wire logic        i_cmp_hi,
  output logic      [4:0]  o_chan_sel,
  output logic             o_chan_en,
  output logic      [11:0] o_dac,
  output logic             o_sampling,
  output logic             o_conv_irq
);
  // ----------------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------------
  logic [7:0]  sc1_r;
  logic [2:0]  sc2_r;
  logic [7:0]  cfg_r;
  logic [2:0]  pwr_r;
  logic [11:0] cmpv_r;
  logic [11:0] data_r;
  logic        conversion_complete_flag_r;
  logic [7:0]  rdata_r;
  logic [2:0]  trig_sync_r;
  logic        cont_run_r;

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  wire wr_sc1  = i_wr & hit(i_addr, conv_ctrl_pkg::OFS_SC1);
  wire wr_sc2  = i_wr & hit(i_addr, conv_ctrl_pkg::OFS_SC2);
  wire wr_cfg  = i_wr & hit(i_addr, conv_ctrl_pkg::OFS_CFG);
  wire wr_pwr  = i_wr & hit(i_addr, conv_ctrl_pkg::OFS_PWR);
  wire wr_cmph = i_wr & hit(i_addr, conv_ctrl_pkg::OFS_CMP_HI);
  wire wr_cmpl = i_wr & hit(i_addr, conv_ctrl_pkg::OFS_CMP_LO);
  wire rd_lo   = i_rd & hit(i_addr, conv_ctrl_pkg::OFS_RES_LO);

  wire [4:0] chan     = sc1_r[4:0];
  wire       chan_off = (chan == conv_ctrl_pkg::CH_OFF);
  wire       hw_mode  = sc2_r[2];
  wire       cmp_en   = sc2_r[1];
  wire       cmp_ge   = sc2_r[0];
  wire [1:0] src_sel  = cfg_r[1:0];
  wire [1:0] fmt_mode = cfg_r[conv_ctrl_pkg::CFG_MODE_LO +: 2];
  wire [1:0] div_sel  = cfg_r[conv_ctrl_pkg::CFG_DIV_LO +: 2];
  wire       long_smp = cfg_r[conv_ctrl_pkg::CFG_LSMP];
  wire       in_stop23 = pwr_r[conv_ctrl_pkg::PWR_STOP2] | pwr_r[conv_ctrl_pkg::PWR_STOP3];
  wire       in_stop2  = pwr_r[conv_ctrl_pkg::PWR_STOP2];

  // ----------------------------------------------------------------------
  // Triggers
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      trig_sync_r <= 3'h0;
    end else begin
      trig_sync_r <= {trig_sync_r[1:0], i_hw_trig};
    end
  end

  // Overflow pulse accepted in run, wait and stop3; only stop2 powers it down
  wire hw_edge  = trig_sync_r[1] & ~trig_sync_r[2];
  wire hw_start = hw_mode & hw_edge & ~chan_off & ~in_stop2;
  wire sw_start = wr_sc1 & ~hw_mode & (i_wdata[4:0] != conv_ctrl_pkg::CH_OFF);
  wire abort    = wr_sc1 | chan_off;

  // ----------------------------------------------------------------------
  // Clock generator and sequencer
  // ----------------------------------------------------------------------
  logic        tick;
  logic        busy;
  logic        done;
  logic [11:0] raw;

  conv_clk_gen u_clk (
    .i_clk_sys   (i_clk_sys),
    .i_rst_n     (i_rst_n),
    .i_src       (src_sel),
    .i_div       (div_sel),
    .i_alt_clk   (i_alt_clk),
    .i_local_clk (i_local_clk),
    .i_alt_ok    (~in_stop23),
    .o_tick      (tick)
  );

  // Continuous re-arm after each completion unless switched off
  wire cont_again = done & sc1_r[conv_ctrl_pkg::SC1_CONT] & ~chan_off
                    & (~hw_mode | cont_run_r);
  // A write that switches off or restarts must not be overtaken by a re-arm
  wire off_wr     = wr_sc1 & (i_wdata[4:0] == conv_ctrl_pkg::CH_OFF);
  wire start      = sw_start | (hw_start & ~off_wr) | (cont_again & ~wr_sc1);

  conv_sar_core #(
    .BITS (conv_ctrl_pkg::RES_BITS)
  ) u_core (
    .i_clk_sys  (i_clk_sys),
    .i_rst_n    (i_rst_n),
    .i_start    (start),
    .i_abort    (abort),
    .i_tick     (tick),
    .i_long     (long_smp),
    .i_cmp_hi   (i_cmp_hi),
    .o_dac      (o_dac),
    .o_sampling (o_sampling),
    .o_busy     (busy),
    .o_done     (done),
    .o_result   (raw)
  );

  // ----------------------------------------------------------------------
  // Result format and compare
  // ----------------------------------------------------------------------
  wire [11:0] fmt = (fmt_mode == conv_ctrl_pkg::MODE_12) ? raw :
                    (fmt_mode == conv_ctrl_pkg::MODE_10) ? {2'h0, raw[11:2]} :
                                                           {4'h0, raw[11:4]};
  wire cmp_true = cmp_ge ? (fmt >= cmpv_r) : (fmt < cmpv_r);
  wire take     = done & (~cmp_en | cmp_true);
  wire clr_conversion_complete_flag = wr_sc1 | rd_lo;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      data_r <= 12'h000;
      conversion_complete_flag_r <= 1'b0;
    end else begin
      if (take) begin
        data_r <= fmt;
      end
      conversion_complete_flag_r <= take | (conversion_complete_flag_r & ~clr_conversion_complete_flag);
    end
  end

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sc1_r      <= conv_ctrl_pkg::SC1_RST;
      sc2_r      <= 3'h0;
      cfg_r      <= conv_ctrl_pkg::CFG_RST;
      pwr_r      <= 3'h0;
      cmpv_r     <= 12'h000;
      cont_run_r <= 1'b0;
    end else begin
      if (wr_sc1) begin
        sc1_r <= i_wdata;
      end
      if (wr_sc2) begin
        sc2_r <= i_wdata[6:4];
      end
      if (wr_cfg) begin
        cfg_r <= i_wdata;
      end
      if (wr_pwr) begin
        pwr_r <= i_wdata[2:0];
      end
      if (wr_cmph) begin
        cmpv_r[11:8] <= i_wdata[3:0];
      end
      if (wr_cmpl) begin
        cmpv_r[7:0] <= i_wdata;
      end
      // Hardware continuous mode runs from the first overflow
      if (wr_sc1 | chan_off) begin
        cont_run_r <= 1'b0;
      end else if (hw_start) begin
        cont_run_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Channel routing: codes 26/27 map to internal sensors, reserved codes
  // are passed through and give whatever the mux delivers
  // ----------------------------------------------------------------------
  assign o_chan_sel = chan;
  assign o_chan_en  = busy & ~chan_off;

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  wire [7:0] sc1_rd = {conversion_complete_flag_r, sc1_r[6:0]};
  wire [7:0] sc2_rd = {busy, sc2_r, 4'h0};
  wire [7:0] rd_mux =
    hit(i_addr, conv_ctrl_pkg::OFS_SC1)    ? sc1_rd :
    hit(i_addr, conv_ctrl_pkg::OFS_SC2)    ? sc2_rd :
    hit(i_addr, conv_ctrl_pkg::OFS_RES_HI) ? {4'h0, data_r[11:8]} :
    hit(i_addr, conv_ctrl_pkg::OFS_RES_LO) ? data_r[7:0] :
    hit(i_addr, conv_ctrl_pkg::OFS_CMP_HI) ? {4'h0, cmpv_r[11:8]} :
    hit(i_addr, conv_ctrl_pkg::OFS_CMP_LO) ? cmpv_r[7:0] :
    hit(i_addr, conv_ctrl_pkg::OFS_CFG)    ? cfg_r :
    hit(i_addr, conv_ctrl_pkg::OFS_PWR)    ? {5'h00, pwr_r} : 8'h00;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= i_rd ? rd_mux : 8'h00;
    end
  end

  assign o_rdata    = rdata_r;
  assign o_conv_irq = conversion_complete_flag_r & sc1_r[conv_ctrl_pkg::SC1_AIEN];
endmodule : conv_ctrl
`default_nettype wire

// ### verilog/conv_ctrl_pkg.sv
// Package: register offsets, field positions, reset values and timing counts
// Assumes: shared by the converter control top and its two helper modules
package conv_ctrl_pkg;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses on the plain register port)
  // ----------------------------------------------------------------------
  localparam logic [3:0] OFS_SC1     = 4'h0;
  localparam logic [3:0] OFS_SC2     = 4'h1;
  localparam logic [3:0] OFS_RES_HI  = 4'h2;
  localparam logic [3:0] OFS_RES_LO  = 4'h3;
  localparam logic [3:0] OFS_CMP_HI  = 4'h4;
  localparam logic [3:0] OFS_CMP_LO  = 4'h5;
  localparam logic [3:0] OFS_CFG     = 4'h6;
  localparam logic [3:0] OFS_PWR     = 4'h7;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int SC1_CONVERSION_COMPLETE_FLAG   = 7;
  localparam int SC1_AIEN   = 6;
  localparam int SC1_CONT   = 5;
  localparam int SC2_ACT    = 7;
  localparam int SC2_TRG    = 6;
  localparam int SC2_CMPEN  = 5;
  localparam int SC2_CMPGT  = 4;
  localparam int CFG_MODE_LO = 2;
  localparam int CFG_DIV_LO  = 5;
  localparam int CFG_LSMP    = 4;
  localparam int PWR_WAIT   = 0;
  localparam int PWR_STOP2  = 1;
  localparam int PWR_STOP3  = 2;

  // ----------------------------------------------------------------------
  // Channel codes and encodings
  // ----------------------------------------------------------------------
  localparam logic [4:0] CH_TEMP     = 5'h1a;
  localparam logic [4:0] CH_BANDGAP  = 5'h1b;
  localparam logic [4:0] CH_OFF      = 5'h1f;
  localparam logic [4:0] CH_LAST_PIN = 5'h17;
  localparam logic [4:0] CH_RSV_A    = 5'h18;
  localparam logic [4:0] CH_RSV_B    = 5'h19;
  localparam logic [4:0] CH_RSV_C    = 5'h1c;

  localparam logic [1:0] SRC_BUS     = 2'h0;
  localparam logic [1:0] SRC_BUS_DIV2 = 2'h1;
  localparam logic [1:0] SRC_ALT     = 2'h2;
  localparam logic [1:0] SRC_LOCAL   = 2'h3;

  localparam logic [1:0] MODE_8      = 2'h0;
  localparam logic [1:0] MODE_12     = 2'h1;
  localparam logic [1:0] MODE_10     = 2'h2;

  // ----------------------------------------------------------------------
  // Reset values and timing counts
  // ----------------------------------------------------------------------
  localparam logic [7:0] SC1_RST     = 8'h1f;
  localparam logic [7:0] CFG_RST     = 8'h00;
  localparam int         SAMPLE_SHORT = 4;
  localparam int         SAMPLE_LONG  = 24;
  localparam int         RES_BITS     = 12;

endpackage : conv_ctrl_pkg

// ### verilog/conv_sar_core.sv
// Successive approximation sequencer: sample, then one bit per tick
// Assumes: comparator answer from the analog side is already synchronous
`timescale 1ns/10ps
`default_nettype none
module conv_sar_core #(
  parameter int BITS = 12
) (
  input  wire logic            i_clk_sys,
  input  wire logic            i_rst_n,
  input  wire logic            i_start,
  input  wire logic            i_abort,
  input  wire logic            i_tick,
  input  wire logic            i_long,
  input  wire logic            i_cmp_hi,
  output logic [BITS-1:0]      o_dac,
  output logic                 o_sampling,
  output logic                 o_busy,
  output logic                 o_done,
  output logic [BITS-1:0]      o_result
);
  logic [4:0]       cnt_r;
  logic [BITS-1:0]  trial_r;
  logic [BITS-1:0]  res_r;
  logic [BITS-1:0]  bit_r;
  logic             busy_r;
  logic             samp_r;
  logic             done_r;
  wire  [4:0]       samp_len = i_long ? 5'(conv_ctrl_pkg::SAMPLE_LONG)
                                      : 5'(conv_ctrl_pkg::SAMPLE_SHORT);

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r   <= 5'h0;
      trial_r <= '0;
      res_r   <= '0;
      bit_r   <= '0;
      busy_r  <= 1'b0;
      samp_r  <= 1'b0;
      done_r  <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (i_abort) begin
        busy_r <= 1'b0;
        samp_r <= 1'b0;
      end
      if (i_start) begin
        busy_r  <= 1'b1;
        samp_r  <= 1'b1;
        cnt_r   <= 5'h0;
        bit_r   <= {1'b1, {(BITS-1){1'b0}}};
        trial_r <= {1'b1, {(BITS-1){1'b0}}};
      end else if (busy_r && i_tick) begin
        if (samp_r) begin
          cnt_r <= cnt_r + 5'h1;
          if (cnt_r + 5'h1 >= samp_len) begin
            samp_r <= 1'b0;
          end
        end else begin
          if (!i_cmp_hi) begin
            trial_r <= trial_r & ~bit_r;
          end
          if (bit_r[0]) begin
            busy_r <= 1'b0;
            done_r <= 1'b1;
            res_r  <= i_cmp_hi ? trial_r : (trial_r & ~bit_r);
          end else begin
            trial_r <= (i_cmp_hi ? trial_r : (trial_r & ~bit_r)) | (bit_r >> 1);
            bit_r   <= bit_r >> 1;
          end
        end
      end
    end
  end

  assign o_dac      = trial_r;
  assign o_sampling = samp_r;
  assign o_busy     = busy_r;
  assign o_done     = done_r;
  assign o_result   = res_r;
endmodule : conv_sar_core
`default_nettype wire
